// ==== verilog/rx_chain_consts.vh ====
// constants for the receive buffer descriptor chain engine
`ifndef RX_CHAIN_CONSTS_VH
`define RX_CHAIN_CONSTS_VH
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_CFG       8'h04
`define OFF_FD_SIZE   8'h08
`define OFF_FD_ADDR   8'h0C
`define OFF_LIST_HEAD 8'h10
`define OFF_SEG_BASE  8'h14
`define OFF_STATUS    8'h18
`define OFF_FRAMES    8'h1C
// reset values
`define CFG_RST       32'h00000660
`define ZERO_RST      32'h00000000
// configuration and control fields
`define CFG_SF_BIT    2
`define CFG_PF_BIT    3
`define CFG_DA_LSB    4
`define CFG_SA_LSB    8
`define CTRL_START    0
// addressing modes and header lengths
`define MODE_COMPAT   2'h0
`define MODE_SEG      2'h1
`define MODE_LIN      2'h2
`define HDR_MAX       3'h6
`define LEN_FIELD     16'h0002
// descriptor fields
`define DESC_EOF_BIT  15
`define DESC_USED_BIT 14
`define DESC_EL_BIT   15
`define DESC_PF_BIT   14
`define SZW_OFF_SEG   32'h00000008
`define SZW_OFF_LIN   32'h0000000C
`define FD_HDR_SEG    32'h0000000C
`define FD_HDR_LIN    32'h00000010
`define ADDR24_MASK   32'h00FFFFFF
// bus answers
`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3
`endif

// ==== verilog/rx_buffer_descriptor_chain.v ====
// receive buffer descriptor chain engine with an AXI4-Lite register slave
// Functional notes
// - destination and source address fields stored as received, length 0..6 bytes each
// - two-byte length field stored in arrival order, high byte first
// - address and length fields packed with no padding between them
// - compatibility mode puts header bytes into data buffers, not the frame descriptor
// - simplified structure puts header fields into frame descriptor positions
// - flexible structure fills frame descriptor with header bytes only, up to its size, rest into buffers
// - buffer address is 24-bit in compatibility mode, 32-bit otherwise
// - next link is offset or absolute address, ignored when list end flag set
// - end-of-frame flag set in descriptor of the frame's final data buffer
// - buffer-used flag set after filling; count valid only while it is one
// - fourteen-bit byte count written back after a buffer is used
// - full buffers report their size; only the final buffer may report less
// - descriptor with list end flag holds the last free buffer
// - prefetch marking reads descriptors locked, then one write setting prefetched flag
// - prefetched flag written only in segmented or linear mode when enabled
// - prefetched flag set without reading or testing it first; the code ORs it into the size word it read, untested
// - never write more bytes into a buffer than its size allows
// - next descriptor fetched before the current buffer is exhausted
// - exhausted free buffer list puts the receive unit in no-resources state
`timescale 1ns/1ps
`include "rx_chain_consts.vh"
module rx_buffer_descriptor_chain (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite register slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // received frame byte stream
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_last,
  output wire        rx_ready,
  // shared memory master
  output wire        mem_req,
  output wire        mem_we,
  output wire        mem_lock,
  output wire [31:0] mem_addr,
  output wire [3:0]  mem_be,
  output wire [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // state
  output wire        rx_no_resources
);
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_RD    = 7'h02;
  localparam [6:0] S_PM    = 7'h04;
  localparam [6:0] S_WAIT  = 7'h08;
  localparam [6:0] S_WR    = 7'h10;
  localparam [6:0] S_WBK   = 7'h20;
  localparam [6:0] S_NORES = 7'h40;

  function hit;
    input [7:0] a;
    begin
      hit = (a == `OFF_CTRL) || (a == `OFF_CFG) || (a == `OFF_FD_SIZE) ||
            (a == `OFF_FD_ADDR) || (a == `OFF_LIST_HEAD) || (a == `OFF_SEG_BASE) ||
            (a == `OFF_STATUS) || (a == `OFF_FRAMES);
    end
  endfunction

  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0]  s;
    integer k;
    begin
      merge = o;
      for (k = 0; k < 4; k = k + 1)
        if (s[k])
          merge[k*8 +: 8] = n[k*8 +: 8];
    end
  endfunction

  // offsets are relative to the segment base except in linear mode
  function [31:0] link_addr;
    input [1:0]  m;
    input [31:0] base;
    input [31:0] raw;
    begin
      if (m == `MODE_LIN)
        link_addr = raw;
      else
        link_addr = base + {16'h0000, raw[15:0]};
    end
  endfunction

  // software registers
  reg  [31:0] cfg_reg, fd_size_reg, fd_addr_reg, head_reg, seg_base_reg;
  reg         start_reg;
  reg         aw_ok_reg, w_ok_reg, bvalid_reg, rvalid_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg, rdata_reg;
  reg  [3:0]  w_strb_reg;
  reg  [1:0]  bresp_reg, rresp_reg;
  // engine state
  reg  [6:0]  st_reg;
  reg  [1:0]  wi_reg;
  reg         tgt_reg, eof_reg, last_reg, tofd_reg;
  reg  [7:0]  byte_reg;
  reg  [31:0] dw_mem [0:3];
  reg  [31:0] daddr_reg;
  reg  [31:0] cur_addr, cur_buf, cur_next, nxt_addr, nxt_buf, nxt_next;
  reg  [15:0] cur_hi, nxt_hi, fidx_reg, frames_reg;
  reg  [13:0] cur_size, nxt_size, cnt_reg;
  reg         cur_el, nxt_el;
  reg         req_reg, we_reg, lock_reg;
  reg  [31:0] addr_reg, wdat_reg;
  reg  [3:0]  be_reg;
  integer     i;

  wire [1:0]  mode   = cfg_reg[1:0];
  wire        compat = (mode == `MODE_COMPAT);
  wire        lin    = (mode == `MODE_LIN);
  wire        sf     = cfg_reg[`CFG_SF_BIT];
  wire        pf_on  = cfg_reg[`CFG_PF_BIT] & ~compat;
  wire [2:0]  da_raw = cfg_reg[`CFG_DA_LSB +: 3];
  wire [2:0]  sa_raw = cfg_reg[`CFG_SA_LSB +: 3];
  wire [2:0]  da_len = (da_raw > `HDR_MAX) ? `HDR_MAX : da_raw;
  wire [2:0]  sa_len = (sa_raw > `HDR_MAX) ? `HDR_MAX : sa_raw;
  wire [15:0] hdr_len = {13'h0000, da_len} + {13'h0000, sa_len} + `LEN_FIELD;
  wire [13:0] fd_size = fd_size_reg[13:0];

  // descriptor decode from the words just read
  wire [31:0] szw    = lin ? dw_mem[3] : dw_mem[2];
  wire [31:0] d_buf  = lin ? dw_mem[2] : (compat ? (dw_mem[1] & `ADDR24_MASK) : dw_mem[1]);
  wire [31:0] d_next = link_addr(mode, seg_base_reg,
                                 lin ? dw_mem[1] : {16'h0000, dw_mem[0][31:16]});
  wire        d_el   = szw[`DESC_EL_BIT];
  wire [1:0]  nw_last = lin ? 2'h3 : 2'h2;
  wire [31:0] szw_off = lin ? `SZW_OFF_LIN : `SZW_OFF_SEG;

  // byte routing: header into the frame descriptor or into the buffers
  wire        in_fd = fidx_reg < {2'b00, fd_size};
  wire        to_fd = ~compat & in_fd & (~sf | (fidx_reg < hdr_len));
  wire        drop  = ~compat & ~sf & ~in_fd;
  wire        full  = (cnt_reg == cur_size);
  wire        st_wait = (st_reg == S_WAIT);
  wire        st_nores = (st_reg == S_NORES);
  wire [31:0] fd_off = lin ? `FD_HDR_LIN : `FD_HDR_SEG;
  wire [31:0] waddr_raw = tofd_reg ? (fd_addr_reg + fd_off + {16'h0000, fidx_reg})
                                   : (cur_buf + {18'h00000, cnt_reg});
  wire [31:0] waddr = compat ? (waddr_raw & `ADDR24_MASK) : waddr_raw;
  wire [13:0] cnt_n = cnt_reg + {13'h0000, ~tofd_reg};
  wire        fin   = ~pf_on | (req_reg & mem_ack);

  // a full buffer holds back the next buffer byte until the chain has moved on
  assign rx_ready = st_nores | (st_wait & (to_fd | drop | ~full));
  assign rx_no_resources = st_nores;
  assign mem_req   = req_reg;
  assign mem_we    = we_reg;
  assign mem_lock  = lock_reg;
  assign mem_addr  = addr_reg;
  assign mem_be    = be_reg;
  assign mem_wdata = wdat_reg;

  assign s_axi_awready = ~aw_ok_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_ok_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // register slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `ZERO_RST;
      w_strb_reg <= 4'h0;
      bresp_reg <= `RESP_OKAY;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= `ZERO_RST;
      cfg_reg <= `CFG_RST;
      fd_size_reg <= `ZERO_RST;
      fd_addr_reg <= `ZERO_RST;
      head_reg <= `ZERO_RST;
      seg_base_reg <= `ZERO_RST;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_ok_reg && w_ok_reg) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= hit(aw_addr_reg) ? `RESP_OKAY : `RESP_DECERR;
        case (aw_addr_reg)
          `OFF_CTRL: start_reg <= w_strb_reg[0] & w_data_reg[`CTRL_START];
          `OFF_CFG: cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg);
          `OFF_FD_SIZE: fd_size_reg <= merge(fd_size_reg, w_data_reg, w_strb_reg);
          `OFF_FD_ADDR: fd_addr_reg <= merge(fd_addr_reg, w_data_reg, w_strb_reg);
          `OFF_LIST_HEAD: head_reg <= merge(head_reg, w_data_reg, w_strb_reg);
          `OFF_SEG_BASE: seg_base_reg <= merge(seg_base_reg, w_data_reg, w_strb_reg);
          default: start_reg <= 1'b0;
        endcase
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= hit(s_axi_araddr) ? `RESP_OKAY : `RESP_DECERR;
        case (s_axi_araddr)
          `OFF_CFG: rdata_reg <= cfg_reg;
          `OFF_FD_SIZE: rdata_reg <= {18'h00000, fd_size};
          `OFF_FD_ADDR: rdata_reg <= fd_addr_reg;
          `OFF_LIST_HEAD: rdata_reg <= head_reg;
          `OFF_SEG_BASE: rdata_reg <= seg_base_reg;
          `OFF_STATUS: rdata_reg <= {10'h000, cnt_reg, st_nores, st_reg};
          `OFF_FRAMES: rdata_reg <= {16'h0000, frames_reg};
          default: rdata_reg <= `ZERO_RST;
        endcase
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // descriptor and data engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= S_IDLE;
      wi_reg <= 2'h0;
      tgt_reg <= 1'b0;
      eof_reg <= 1'b0;
      last_reg <= 1'b0;
      tofd_reg <= 1'b0;
      byte_reg <= 8'h00;
      for (i = 0; i < 4; i = i + 1)
        dw_mem[i] <= `ZERO_RST;
      daddr_reg <= `ZERO_RST;
      cur_addr <= `ZERO_RST;
      cur_buf <= `ZERO_RST;
      cur_next <= `ZERO_RST;
      nxt_addr <= `ZERO_RST;
      nxt_buf <= `ZERO_RST;
      nxt_next <= `ZERO_RST;
      cur_hi <= 16'h0000;
      nxt_hi <= 16'h0000;
      fidx_reg <= 16'h0000;
      frames_reg <= 16'h0000;
      cur_size <= 14'h0000;
      nxt_size <= 14'h0000;
      cnt_reg <= 14'h0000;
      cur_el <= 1'b1;
      nxt_el <= 1'b1;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      lock_reg <= 1'b0;
      addr_reg <= `ZERO_RST;
      wdat_reg <= `ZERO_RST;
      be_reg <= 4'h0;
    end else begin
      case (st_reg)
        S_IDLE, S_NORES: begin
          // in no-resources the rest of the stream is drained and lost
          if (start_reg) begin
            daddr_reg <= link_addr(mode, seg_base_reg, head_reg);
            tgt_reg <= 1'b0;
            wi_reg <= 2'h0;
            cnt_reg <= 14'h0000;
            fidx_reg <= 16'h0000;
            st_reg <= S_RD;
          end
        end
        S_RD: begin
          if (!req_reg) begin
            req_reg <= 1'b1;
            we_reg <= 1'b0;
            lock_reg <= pf_on;
            be_reg <= 4'hF;
            addr_reg <= daddr_reg + {28'h0000000, wi_reg, 2'b00};
          end else if (mem_ack) begin
            req_reg <= 1'b0;
            dw_mem[wi_reg] <= mem_rdata;
            if (wi_reg == nw_last)
              st_reg <= S_PM;
            else
              wi_reg <= wi_reg + 2'h1;
          end
        end
        S_PM: begin
          if (pf_on && !req_reg) begin
            // the size word is rewritten as read, prefetched bit forced on
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            be_reg <= 4'hF;
            addr_reg <= daddr_reg + szw_off;
            wdat_reg <= szw | (32'h00000001 << `DESC_PF_BIT);
          end else if (fin) begin
            req_reg <= 1'b0;
            lock_reg <= 1'b0;
            // later host edits of this descriptor are never re-read
            if (!tgt_reg) begin
              cur_addr <= daddr_reg;
              cur_buf <= d_buf;
              cur_next <= d_next;
              cur_hi <= dw_mem[0][31:16];
              cur_size <= szw[13:0];
              cur_el <= d_el;
              cnt_reg <= 14'h0000;
              if (!d_el) begin
                tgt_reg <= 1'b1;
                daddr_reg <= d_next;
                wi_reg <= 2'h0;
                st_reg <= S_RD;
              end else begin
                st_reg <= S_WAIT;
              end
            end else begin
              nxt_addr <= daddr_reg;
              nxt_buf <= d_buf;
              nxt_next <= d_next;
              nxt_hi <= dw_mem[0][31:16];
              nxt_size <= szw[13:0];
              nxt_el <= d_el;
              st_reg <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (rx_valid && rx_ready) begin
            byte_reg <= rx_data;
            last_reg <= rx_last;
            tofd_reg <= to_fd;
            if (drop) begin
              fidx_reg <= rx_last ? 16'h0000 : fidx_reg + 16'h0001;
              if (rx_last)
                frames_reg <= frames_reg + 16'h0001;
            end else begin
              st_reg <= S_WR;
            end
          end else if (rx_valid && full) begin
            eof_reg <= 1'b0;
            st_reg <= S_WBK;
          end
        end
        S_WR: begin
          if (!req_reg) begin
            // bytes land in arrival order at consecutive addresses
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            addr_reg <= waddr;
            be_reg <= 4'h1 << waddr[1:0];
            wdat_reg <= {4{byte_reg}};
          end else if (mem_ack) begin
            req_reg <= 1'b0;
            fidx_reg <= fidx_reg + 16'h0001;
            cnt_reg <= cnt_n;
            if (last_reg && cnt_n != 14'h0000) begin
              eof_reg <= 1'b1;
              st_reg <= S_WBK;
            end else if (last_reg) begin
              fidx_reg <= 16'h0000;
              frames_reg <= frames_reg + 16'h0001;
              st_reg <= S_WAIT;
            end else begin
              st_reg <= S_WAIT;
            end
          end
        end
        S_WBK: begin
          if (!req_reg) begin
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            be_reg <= 4'hF;
            addr_reg <= cur_addr;
            wdat_reg <= {lin ? 16'h0000 : cur_hi, eof_reg, 1'b1, cnt_reg};
          end else if (mem_ack) begin
            req_reg <= 1'b0;
            if (eof_reg) begin
              fidx_reg <= 16'h0000;
              frames_reg <= frames_reg + 16'h0001;
            end
            if (cur_el) begin
              st_reg <= S_NORES;
            end else begin
              cur_addr <= nxt_addr;
              cur_buf <= nxt_buf;
              cur_next <= nxt_next;
              cur_hi <= nxt_hi;
              cur_size <= nxt_size;
              cur_el <= nxt_el;
              cnt_reg <= 14'h0000;
              if (!nxt_el) begin
                tgt_reg <= 1'b1;
                daddr_reg <= nxt_next;
                wi_reg <= 2'h0;
                st_reg <= S_RD;
              end else begin
                st_reg <= S_WAIT;
              end
            end
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/rx_chain_checker.sv ====
// port-level assertions for the receive buffer descriptor chain engine
`timescale 1ns/1ps
`include "rx_chain_consts.vh"
module rx_chain_checker (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register slave
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  // byte stream and memory port
  input wire        rx_valid,
  input wire        rx_ready,
  input wire        mem_req,
  input wire        mem_we,
  input wire        mem_lock,
  input wire [31:0] mem_addr,
  input wire [3:0]  mem_be,
  input wire [31:0] mem_wdata,
  input wire        mem_ack,
  input wire        rx_no_resources
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence req_waiting;
    mem_req && !mem_ack;
  endsequence
  sequence byte_write;
    mem_req && mem_we && !mem_lock && mem_be != 4'hF;
  endsequence
  write_resp_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready during response");
  resp_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after acceptance");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready during read data");
  req_hold_a: assert property (req_waiting |=> mem_req && $stable(mem_addr)
    && $stable(mem_wdata) && $stable(mem_be) && $stable(mem_we))
    else $error("memory request changed before ack");
  req_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not dropped after ack");
  byte_lane_a: assert property (byte_write |-> mem_be == (4'h1 << mem_addr[1:0])
    && mem_wdata == {4{mem_wdata[7:0]}})
    else $error("byte write lane or data wrong");
  mark_write_a: assert property (mem_req && mem_we && mem_lock |-> mem_wdata[`DESC_PF_BIT])
    else $error("locked write without prefetched flag");
  used_flag_a: assert property (mem_req && mem_we && !mem_lock && mem_be == 4'hF
    |-> mem_wdata[`DESC_USED_BIT] && mem_wdata[13:0] != 14'h0)
    else $error("descriptor writeback without used flag or count");
  rx_pace_a: assert property (rx_valid && rx_ready && !rx_no_resources |=> !rx_ready)
    else $error("stream ready not dropped after byte taken");
  nores_ready_a: assert property (rx_no_resources |-> rx_ready)
    else $error("stream not drained in no-resources state");
endmodule
bind rx_buffer_descriptor_chain rx_chain_checker chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .rx_valid, .rx_ready, .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_be,
  .mem_wdata, .mem_ack, .rx_no_resources
);

// ==== tb/rx_mem_model.sv ====
// shared memory model answering the engine's word and byte accesses
`timescale 1ns/1ps
module rx_mem_model (
  // clock, reset and pacing
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        slow,
  // memory port
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [31:0] mem_addr,
  input  wire [3:0]  mem_be,
  input  wire [31:0] mem_wdata,
  output reg         mem_ack,
  output reg  [31:0] mem_rdata,
  // accesses beyond the modelled 4 KiB
  output reg  [7:0]  stray
);
  reg [31:0] ram [0:1023];
  reg [1:0]  wait_cnt;
  integer    k;
  initial begin
    for (k = 0; k < 1024; k = k + 1)
      ram[k] = 32'h0;
    mem_ack = 1'h0;
    mem_rdata = 32'h5A5A5A5A;
    stray = 8'h0;
    wait_cnt = 2'h0;
  end
  always @(posedge aclk) begin
    mem_ack <= 1'h0;
    // read data toggles outside the ack so a late sample never looks valid
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      wait_cnt <= 2'h0;
    end else if (mem_req && !mem_ack) begin
      if (slow && wait_cnt != 2'h3) begin
        wait_cnt <= wait_cnt + 2'h1;
      end else begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'h1;
        if (mem_addr[31:12] != 20'h0)
          stray <= stray + 8'h1;
        if (!mem_we)
          mem_rdata <= ram[mem_addr[11:2]];
        for (k = 0; k < 4; k = k + 1)
          if (mem_we && mem_be[k])
            ram[mem_addr[11:2]][8*k +: 8] <= mem_wdata[8*k +: 8];
      end
    end
  end
endmodule

// ==== tb/rx_buffer_descriptor_chain_tb.sv ====
// register and frame tests of the receive buffer descriptor chain engine
`timescale 1ns/1ps
`include "rx_chain_consts.vh"
module rx_buffer_descriptor_chain_tb;
  reg        aclk = 1'h0;
  reg        aresetn = 1'h0;
  reg        slow = 1'h1;
  reg        s_axi_awvalid = 1'h0;
  reg        s_axi_wvalid = 1'h0;
  reg        s_axi_arvalid = 1'h0;
  reg        rx_valid = 1'h0;
  reg        rx_last = 1'h0;
  reg  [7:0] s_axi_awaddr = 8'h0;
  reg  [7:0] s_axi_araddr = 8'h0;
  reg  [7:0] rx_data = 8'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire       rx_ready, mem_req, mem_we, mem_lock, mem_ack, rx_no_resources;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [3:0] mem_be;
  wire [7:0] stray;
  wire [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
  integer    err_total = 0;
  integer    checks = 0;
  always #25 aclk = ~aclk;
  rx_buffer_descriptor_chain dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'h1), .rx_valid, .rx_data, .rx_last, .rx_ready, .mem_req, .mem_we,
    .mem_lock, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata, .rx_no_resources
  );
  rx_mem_model mem (
    .aclk, .aresetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
    .mem_ack, .mem_rdata, .stray
  );
  task end_sim;
    begin
      if (err_total == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // bready and rready stay high, so an answer is taken at the edge it is seen
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      cmp("rdata", e, s_axi_rdata & m);
      cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    end
  endtask
  // bytes go back to back; valid stays up for the whole frame
  task frame(input [7:0] first, input integer n);
    integer i;
    begin
      rx_valid <= 1'h1;
      for (i = 0; i < n; i = i + 1) begin
        rx_data <= first + i[7:0];
        rx_last <= (i == n - 1);
        do @(posedge aclk); while (!rx_ready);
      end
      rx_valid <= 1'h0;
      rx_last <= 1'h0;
      while (!rx_no_resources) @(posedge aclk);
    end
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(`OFF_CFG, `CFG_RST, 32'hFFFFFFFF, `RESP_OKAY);
    wr(8'h40, 32'h1, `RESP_DECERR);
    rd_chk(8'h40, 32'h0, 32'hFFFFFFFF, `RESP_DECERR);
    wr(`OFF_STATUS, 32'hFFFFFFFF, `RESP_OKAY);
    rd_chk(`OFF_STATUS, 32'h1, 32'hFFFFFFFF, `RESP_OKAY);
    // segmented, flexible, prefetch marking, 2+2 address bytes, slow memory
    mem.ram[10'h10] = 32'h00500000;
    mem.ram[10'h11] = 32'h00000200;
    mem.ram[10'h12] = 32'h00000004;
    mem.ram[10'h16] = 32'h00008008;
    mem.ram[10'h15] = 32'h00000300;
    wr(`OFF_LIST_HEAD, 32'h40, `RESP_OKAY);
    wr(`OFF_FD_ADDR, 32'h80, `RESP_OKAY);
    wr(`OFF_FD_SIZE, 32'h4, `RESP_OKAY);
    wr(`OFF_CFG, 32'h0000022D, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    frame(8'h10, 12);
    rd_chk(`OFF_STATUS, 32'hC0, 32'hFF, `RESP_OKAY);
    cmp("fd header", 32'h13121110, mem.ram[10'h23]);
    cmp("buf0", 32'h17161514, mem.ram[10'h80]);
    cmp("buf0 over", 32'h0, mem.ram[10'h81]);
    cmp("buf1", 32'h1B1A1918, mem.ram[10'hC0]);
    cmp("desc0 w0", 32'h00504004, mem.ram[10'h10]);
    cmp("desc1 w0", 32'h0000C004, mem.ram[10'h14]);
    cmp("desc0 w2", 32'h00004004, mem.ram[10'h12]);
    cmp("desc1 w2", 32'h0000C008, mem.ram[10'h16]);
    // compatibility mode: upper address byte must be dropped, no marking
    slow <= 1'h0;
    mem.ram[10'h19] = 32'hAB000400;
    mem.ram[10'h1A] = 32'h00008010;
    mem.ram[10'h2B] = 32'hFFFFFFFF;
    wr(`OFF_LIST_HEAD, 32'h60, `RESP_OKAY);
    wr(`OFF_FD_ADDR, 32'hA0, `RESP_OKAY);
    wr(`OFF_CFG, 32'h0000022C, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    frame(8'h20, 8);
    cmp("cbuf lo", 32'h23222120, mem.ram[10'h100]);
    cmp("cbuf hi", 32'h27262524, mem.ram[10'h101]);
    cmp("cfd unused", 32'hFFFFFFFF, mem.ram[10'h2B]);
    cmp("cdesc w0", 32'h0000C008, mem.ram[10'h18]);
    cmp("cdesc w2", 32'h00008010, mem.ram[10'h1A]);
    cmp("stray", 32'h0, {24'h0, stray});
    cmp("nores", 32'h1, {31'h0, rx_no_resources});
    // linear, flexible, marking off: absolute links, segment base ignored
    mem.ram[10'h38] = 32'hABCD0000;
    mem.ram[10'h39] = 32'h000000F0;
    mem.ram[10'h3A] = 32'h00000500;
    mem.ram[10'h3B] = 32'h00000002;
    mem.ram[10'h3E] = 32'h00000600;
    mem.ram[10'h3F] = 32'h00008004;
    wr(`OFF_SEG_BASE, 32'h100, `RESP_OKAY);
    wr(`OFF_LIST_HEAD, 32'hE0, `RESP_OKAY);
    wr(`OFF_CFG, 32'h00000226, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    frame(8'h30, 8);
    cmp("lfd header", 32'h33323130, mem.ram[10'h2C]);
    cmp("lbuf0", 32'h00003534, mem.ram[10'h140]);
    cmp("lbuf1", 32'h00003736, mem.ram[10'h180]);
    cmp("ldesc0 w0", 32'h00004002, mem.ram[10'h38]);
    cmp("ldesc1 w0", 32'h0000C002, mem.ram[10'h3C]);
    cmp("ldesc0 w3", 32'h00000002, mem.ram[10'h3B]);
    rd_chk(`OFF_FRAMES, 32'h3, 32'hFFFFFFFF, `RESP_OKAY);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total = err_total + 1;
    end_sim;
  end
endmodule
